// ### fuse_trim_pkg.sv
package fuse_trim_pkg;

    localparam int CLK_PERIOD_NS = 100;

    // Least times, rounded up to whole cycles
    function automatic int us_to_cyc(input int us);
        return (us * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction

    localparam int HI_ACTIVE_US = 30;
    localparam int HI_OFF_US = 30;
    localparam int MID_ACTIVE_US = 15;
    localparam int MID_OFF_US = 5;
    localparam int BLOW_US = 30;
    localparam int HI_ACTIVE_CYC = us_to_cyc(HI_ACTIVE_US);
    localparam int HI_OFF_CYC = us_to_cyc(HI_OFF_US);
    localparam int MID_ACTIVE_CYC = us_to_cyc(MID_ACTIVE_US);
    localparam int MID_OFF_CYC = us_to_cyc(MID_OFF_US);
    localparam int BLOW_CYC = us_to_cyc(BLOW_US);

    localparam int TMR_W = 24;

    localparam logic [7:0] CMD_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] BLOWN_OFS = 8'h08;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_TRY = 3'h1,
        OP_BLOW_BIT = 3'h2,
        OP_PROGRAM = 3'h3,
        OP_POWER_CYCLE = 3'h4
    } op_t;

    localparam logic [1:0] KEY_QUIESCENT = 2'h1;
    localparam logic [1:0] KEY_SENS = 2'h2;
    localparam logic [1:0] KEY_SHARED = 2'h3;

    localparam logic [5:0] MAX_CODE_6B = 6'h3f;
    localparam logic [5:0] MAX_CODE_SHARED = 6'h1f;
    localparam logic [5:0] TC_MAX_CODE = 6'h07;
    localparam logic [5:0] POL_CODE = 6'h08;
    localparam logic [5:0] FREEZE_CODE = 6'h10;

    // Recommended blow order, lowest first
    localparam logic [2:0] RANK_POL = 3'h0;
    localparam logic [2:0] RANK_TC = 3'h1;
    localparam logic [2:0] RANK_SENS = 3'h2;
    localparam logic [2:0] RANK_QUIESCENT = 3'h3;
    localparam logic [2:0] RANK_FREEZE = 3'h4;

    typedef enum logic [1:0] {
        LVL_LOW = 2'h0,
        LVL_STEP = 2'h1,
        LVL_BLOW = 2'h2
    } level_t;

    typedef enum logic [3:0] {
        SEQ_IDLE = 4'h0,
        SEQ_PWR_OFF = 4'h1,
        SEQ_PWR_UP = 4'h2,
        SEQ_SEL_HI = 4'h3,
        SEQ_KEY_MID = 4'h4,
        SEQ_ADDR_HI = 4'h5,
        SEQ_CODE_MID = 4'h6,
        SEQ_BLOW = 4'h7,
        SEQ_SETTLE = 4'h8
    } seq_t;

    typedef struct packed {
        logic supply_on;
        level_t level;
    } pin_drive_t;

    localparam pin_drive_t PIN_DRIVE_RST = '{supply_on: 1'b0, level: LVL_LOW};

    typedef struct packed {
        logic [17:0] rsvd2;
        logic [5:0] code;
        logic [1:0] rsvd1;
        logic [1:0] key;
        logic rsvd0;
        op_t op;
    } cmd_word_t;

    typedef struct packed {
        logic [13:0] rsvd1;
        logic [1:0] key;
        logic [1:0] rsvd0;
        logic [5:0] code;
        seq_t state;
        logic order_warn;
        logic locked;
        logic err;
        logic busy;
    } status_word_t;

    typedef struct packed {
        logic [14:0] rsvd;
        logic [4:0] shared_bits;
        logic [5:0] sens_bits;
        logic [5:0] quiescent_bits;
    } blown_word_t;

endpackage

// ### trim_interval_timer.sv
`timescale 1ns/1ns
module trim_interval_timer #(
    parameter int W = 24
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    output logic expired
);

    logic [W-1:0] count_ff;

    // Loading val gives val+1 cycles until expiry seen by the caller
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            count_ff <= '0;
        else if (ce)
            count_ff <= load ? load_val : (count_ff - ((count_ff != '0) ? W'(1) : W'(0)));
    end

    // No load term here: the caller derives load from expiry, so one would close a loop
    assign expired = (count_ff == '0);

endmodule // trim_interval_timer

// ### fuse_trim_programmer.sv
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ns
module fuse_trim_programmer #(
    parameter int SETTLE_US = 1000,
    parameter int PWR_OFF_US = 10000,
    parameter int PWR_UP_US = 1000
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    output fuse_trim_pkg::pin_drive_t pin_drive
);

    localparam int SETTLE_CYC = fuse_trim_pkg::us_to_cyc(SETTLE_US);
    localparam int PWR_OFF_CYC = fuse_trim_pkg::us_to_cyc(PWR_OFF_US);
    localparam int PWR_UP_CYC = fuse_trim_pkg::us_to_cyc(PWR_UP_US);
    localparam int TW = fuse_trim_pkg::TMR_W;

    fuse_trim_pkg::seq_t state_ff;
    fuse_trim_pkg::seq_t nxt_state;
    logic ph_ff;
    logic nxt_ph;
    logic [5:0] cnt_ff;
    logic [5:0] nxt_cnt;
    fuse_trim_pkg::op_t op_ff;
    logic [1:0] key_ff;
    logic [5:0] code_ff;
    logic [5:0] rem_ff;
    logic pending_ff;
    logic err_ff;
    logic locked_ff;
    logic order_warn_ff;
    logic [2:0] max_rank_ff;
    logic [5:0] blown_q_ff;
    logic [5:0] blown_s_ff;
    logic [4:0] blown_x_ff;
    logic [31:0] rdata_ff;
    fuse_trim_pkg::pin_drive_t pin_drive_ff;
    fuse_trim_pkg::pin_drive_t nxt_drive;
    logic [TW-1:0] tmr_val;

    fuse_trim_pkg::cmd_word_t cmd;
    fuse_trim_pkg::status_word_t st_w;
    fuse_trim_pkg::status_word_t status;
    fuse_trim_pkg::blown_word_t blown;
    logic cmd_wr;
    logic st_wr;
    logic idle;
    logic is_prog;
    logic op_known;
    logic key_ok;
    logic [5:0] max_code;
    logic code_ok;
    logic single_bit;
    logic cmd_ok;
    logic accept;
    logic refuse;
    logic [5:0] cmd_low;
    logic [5:0] low_bit;
    logic tmr_exp;
    logic tmr_load;
    logic settle_done;
    logic pulse_end;
    logic [2:0] rank;
    logic [31:0] rd_val;

    assign cmd = fuse_trim_pkg::cmd_word_t'(wdata);
    assign st_w = fuse_trim_pkg::status_word_t'(wdata);
    assign cmd_wr = wr_stb && (addr == fuse_trim_pkg::CMD_OFS);
    assign st_wr = wr_stb && (addr == fuse_trim_pkg::STATUS_OFS);
    assign idle = (state_ff == fuse_trim_pkg::SEQ_IDLE);
    assign is_prog = (cmd.op == fuse_trim_pkg::OP_TRY) || (cmd.op == fuse_trim_pkg::OP_BLOW_BIT)
        || (cmd.op == fuse_trim_pkg::OP_PROGRAM);
    assign op_known = is_prog || (cmd.op == fuse_trim_pkg::OP_POWER_CYCLE);
    assign key_ok = (cmd.key != 2'h0);
    assign max_code = (cmd.key == fuse_trim_pkg::KEY_SHARED) ? fuse_trim_pkg::MAX_CODE_SHARED
        : fuse_trim_pkg::MAX_CODE_6B;
    assign code_ok = (cmd.code != 6'h00) && (cmd.code <= max_code);
    assign single_bit = ((cmd.code & (cmd.code - 6'h01)) == 6'h00);
    // A host cannot undo a freeze, so try, blow and program commands are refused once one has been blown
    assign cmd_ok = idle && op_known && (!is_prog || (key_ok && code_ok && !locked_ff
        && ((cmd.op != fuse_trim_pkg::OP_BLOW_BIT) || single_bit)));
    assign accept = cmd_wr && cmd_ok;
    assign refuse = cmd_wr && !cmd_ok;
    assign cmd_low = cmd.code & (~cmd.code + 6'h01);
    assign low_bit = rem_ff & (~rem_ff + 6'h01);
    assign pulse_end = tmr_exp && ph_ff;
    assign settle_done = (state_ff == fuse_trim_pkg::SEQ_SETTLE) && tmr_exp;
    assign tmr_load = (nxt_state != state_ff) || (nxt_ph != ph_ff);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_ph = 1'b0;
        unique case (state_ff)
            fuse_trim_pkg::SEQ_IDLE:
                if (accept)
                    nxt_state = fuse_trim_pkg::SEQ_PWR_OFF;
            fuse_trim_pkg::SEQ_PWR_OFF:
                if (tmr_exp)
                    nxt_state = fuse_trim_pkg::SEQ_PWR_UP;
            fuse_trim_pkg::SEQ_PWR_UP:
                if (tmr_exp)
                    nxt_state = pending_ff ? fuse_trim_pkg::SEQ_SEL_HI
                        : fuse_trim_pkg::SEQ_IDLE;
            fuse_trim_pkg::SEQ_SEL_HI,
            fuse_trim_pkg::SEQ_ADDR_HI,
            fuse_trim_pkg::SEQ_KEY_MID,
            fuse_trim_pkg::SEQ_CODE_MID:
            begin
                nxt_ph = tmr_exp ? !ph_ff : ph_ff;
                if (pulse_end)
                begin
                    if (state_ff == fuse_trim_pkg::SEQ_SEL_HI)
                    begin
                        nxt_state = fuse_trim_pkg::SEQ_KEY_MID;
                        nxt_cnt = {4'h0, key_ff};
                    end
                    else if (state_ff == fuse_trim_pkg::SEQ_ADDR_HI)
                    begin
                        nxt_state = fuse_trim_pkg::SEQ_CODE_MID;
                        nxt_cnt = code_ff;
                    end
                    else if (cnt_ff != 6'h01)
                        nxt_cnt = cnt_ff - 6'h01;
                    else if (state_ff == fuse_trim_pkg::SEQ_KEY_MID)
                        nxt_state = fuse_trim_pkg::SEQ_ADDR_HI;
                    else
                        // Try leaves power on so the trial code stays live
                        nxt_state = (op_ff == fuse_trim_pkg::OP_TRY) ? fuse_trim_pkg::SEQ_IDLE
                            : fuse_trim_pkg::SEQ_BLOW;
                end
            end
            fuse_trim_pkg::SEQ_BLOW:
                if (tmr_exp)
                    nxt_state = fuse_trim_pkg::SEQ_SETTLE;
            fuse_trim_pkg::SEQ_SETTLE:
                if (tmr_exp)
                    nxt_state = fuse_trim_pkg::SEQ_PWR_OFF;
            default:
                nxt_state = fuse_trim_pkg::SEQ_IDLE;
        endcase
    end

    always_comb
    begin
        tmr_val = TW'(0);
        nxt_drive.supply_on = 1'b1;
        nxt_drive.level = fuse_trim_pkg::LVL_LOW;
        unique case (nxt_state)
            fuse_trim_pkg::SEQ_IDLE:
                nxt_drive.supply_on = pin_drive_ff.supply_on;
            fuse_trim_pkg::SEQ_PWR_OFF:
            begin
                nxt_drive.supply_on = 1'b0;
                tmr_val = TW'(PWR_OFF_CYC - 1);
            end
            fuse_trim_pkg::SEQ_PWR_UP:
                tmr_val = TW'(PWR_UP_CYC - 1);
            fuse_trim_pkg::SEQ_SEL_HI,
            fuse_trim_pkg::SEQ_ADDR_HI:
            begin
                nxt_drive.level = nxt_ph ? fuse_trim_pkg::LVL_LOW : fuse_trim_pkg::LVL_BLOW;
                tmr_val = nxt_ph ? TW'(fuse_trim_pkg::HI_OFF_CYC - 1)
                    : TW'(fuse_trim_pkg::HI_ACTIVE_CYC - 1);
            end
            fuse_trim_pkg::SEQ_KEY_MID,
            fuse_trim_pkg::SEQ_CODE_MID:
            begin
                nxt_drive.level = nxt_ph ? fuse_trim_pkg::LVL_LOW : fuse_trim_pkg::LVL_STEP;
                tmr_val = nxt_ph ? TW'(fuse_trim_pkg::MID_OFF_CYC - 1)
                    : TW'(fuse_trim_pkg::MID_ACTIVE_CYC - 1);
            end
            fuse_trim_pkg::SEQ_BLOW:
            begin
                nxt_drive.level = fuse_trim_pkg::LVL_BLOW;
                tmr_val = TW'(fuse_trim_pkg::BLOW_CYC - 1);
            end
            fuse_trim_pkg::SEQ_SETTLE:
                tmr_val = TW'(SETTLE_CYC - 1);
            default:
                tmr_val = TW'(0);
        endcase
    end

    trim_interval_timer #(
        .W(TW)
    ) u_timer (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .ce(ce),
        .load(tmr_load),
        .load_val(tmr_val),
        .expired(tmr_exp)
    );

    // Rank of the bit just blown within the recommended order
    assign rank = (key_ff == fuse_trim_pkg::KEY_QUIESCENT) ? fuse_trim_pkg::RANK_QUIESCENT
        : (key_ff == fuse_trim_pkg::KEY_SENS) ? fuse_trim_pkg::RANK_SENS
        : (code_ff == fuse_trim_pkg::FREEZE_CODE) ? fuse_trim_pkg::RANK_FREEZE
        : (code_ff == fuse_trim_pkg::POL_CODE) ? fuse_trim_pkg::RANK_POL
        : (code_ff <= fuse_trim_pkg::TC_MAX_CODE) ? fuse_trim_pkg::RANK_TC
        : fuse_trim_pkg::RANK_FREEZE;

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            state_ff <= fuse_trim_pkg::SEQ_IDLE;
            ph_ff <= 1'b0;
            cnt_ff <= 6'h00;
            pin_drive_ff <= fuse_trim_pkg::PIN_DRIVE_RST;
        end
        else if (ce)
        begin
            state_ff <= nxt_state;
            ph_ff <= nxt_ph;
            cnt_ff <= nxt_cnt;
            pin_drive_ff <= nxt_drive;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            op_ff <= fuse_trim_pkg::OP_NONE;
            key_ff <= 2'h0;
            code_ff <= 6'h00;
            rem_ff <= 6'h00;
            pending_ff <= 1'b0;
        end
        else if (ce && accept)
        begin
            op_ff <= cmd.op;
            key_ff <= cmd.key;
            code_ff <= (cmd.op == fuse_trim_pkg::OP_PROGRAM) ? cmd_low : cmd.code;
            rem_ff <= (cmd.op == fuse_trim_pkg::OP_PROGRAM) ? (cmd.code & ~cmd_low) : 6'h00;
            pending_ff <= is_prog;
        end
        else if (ce && settle_done)
        begin
            code_ff <= low_bit;
            rem_ff <= rem_ff & ~low_bit;
            pending_ff <= (op_ff == fuse_trim_pkg::OP_PROGRAM) && (rem_ff != 6'h00);
        end
    end

    // Shadow of blown fuses: union of every bit blown since reset
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            blown_q_ff <= 6'h00;
            blown_s_ff <= 6'h00;
            blown_x_ff <= 5'h00;
            locked_ff <= 1'b0;
            max_rank_ff <= fuse_trim_pkg::RANK_POL;
        end
        else if (ce && settle_done)
        begin
            if (key_ff == fuse_trim_pkg::KEY_QUIESCENT)
                blown_q_ff <= blown_q_ff | code_ff;
            if (key_ff == fuse_trim_pkg::KEY_SENS)
                blown_s_ff <= blown_s_ff | code_ff;
            if (key_ff == fuse_trim_pkg::KEY_SHARED)
                blown_x_ff <= blown_x_ff | code_ff[4:0];
            if ((key_ff == fuse_trim_pkg::KEY_SHARED) && (code_ff == fuse_trim_pkg::FREEZE_CODE))
                locked_ff <= 1'b1;
            if (rank > max_rank_ff)
                max_rank_ff <= rank;
        end
    end

    // Sticky flags: a new event wins over a clear in the same cycle
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            err_ff <= 1'b0;
            order_warn_ff <= 1'b0;
        end
        else if (ce)
        begin
            err_ff <= refuse || (err_ff && !(st_wr && st_w.err));
            order_warn_ff <= (settle_done && (rank < max_rank_ff))
                || (order_warn_ff && !(st_wr && st_w.order_warn));
        end
    end

    assign status = '{rsvd1: 14'h0000, key: key_ff, rsvd0: 2'h0, code: code_ff,
        state: state_ff, order_warn: order_warn_ff, locked: locked_ff, err: err_ff, busy: !idle};
    assign blown = '{rsvd: 15'h0000, shared_bits: blown_x_ff, sens_bits: blown_s_ff,
        quiescent_bits: blown_q_ff};
    assign rd_val = (addr == fuse_trim_pkg::STATUS_OFS) ? 32'(status)
        : (addr == fuse_trim_pkg::BLOWN_OFS) ? 32'(blown) : 32'h00000000;

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            rdata_ff <= 32'h00000000;
        else if (ce)
            rdata_ff <= rd_stb ? rd_val : 32'h00000000;
    end

    assign rdata = rdata_ff;
    assign pin_drive = pin_drive_ff;

endmodule // fuse_trim_programmer

// ### fuse_trim_checker.sv
`timescale 1ns/1ns
module fuse_trim_checker #(
    parameter int SETTLE_US = 1000,
    parameter int PWR_OFF_US = 10000,
    parameter int PWR_UP_US = 1000
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [31:0] rdata,
    input wire fuse_trim_pkg::pin_drive_t pin_drive
);
    localparam int SETTLE_CYC = fuse_trim_pkg::us_to_cyc(SETTLE_US);
    fuse_trim_pkg::level_t prev_ff;
    fuse_trim_pkg::level_t last_ff;
    logic [15:0] run_ff;
    logic [2:0] hi_ff;
    logic [6:0] mid_ff;
    logic at_low;
    logic at_step;
    logic at_high;
    logic changed;
    logic hi_rise;
    assign at_low = pin_drive.level == fuse_trim_pkg::LVL_LOW;
    assign at_step = pin_drive.level == fuse_trim_pkg::LVL_STEP;
    assign at_high = pin_drive.level == fuse_trim_pkg::LVL_BLOW;
    assign changed = pin_drive.level != prev_ff;
    assign hi_rise = changed && at_high;
    // Run length saturates so a long idle never wraps into a false short gap
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            prev_ff <= fuse_trim_pkg::LVL_LOW;
            last_ff <= fuse_trim_pkg::LVL_LOW;
            run_ff <= 16'h0;
            hi_ff <= 3'h0;
            mid_ff <= 7'h0;
        end
        else
        begin
            prev_ff <= pin_drive.level;
            last_ff <= at_low ? last_ff : pin_drive.level;
            run_ff <= changed ? 16'h1 : run_ff + {15'h0, ~&run_ff};
            hi_ff <= !pin_drive.supply_on ? 3'h0 : hi_ff + {2'h0, hi_rise};
            mid_ff <= hi_rise ? 7'h0 : mid_ff + {6'h0, changed && at_step};
        end
    end
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    sequence blow_start;
        hi_rise;
    endsequence
    sequence level_end(fuse_trim_pkg::level_t l);
        changed && prev_ff == l;
    endsequence
    a_mid_via_low: assert property (at_step |=> !at_high)
        else $error("mid level went straight to high");
    a_high_via_low: assert property (at_high |=> !at_step)
        else $error("high level went straight to mid");
    a_mid_width: assert property (level_end(fuse_trim_pkg::LVL_STEP)
        |-> run_ff >= fuse_trim_pkg::MID_ACTIVE_CYC) else $error("mid pulse too short");
    a_high_width: assert property (level_end(fuse_trim_pkg::LVL_BLOW)
        |-> run_ff >= fuse_trim_pkg::HI_ACTIVE_CYC) else $error("high pulse too short");
    a_gap_after_high: assert property (changed && at_step && last_ff == fuse_trim_pkg::LVL_BLOW
        |-> run_ff >= fuse_trim_pkg::HI_OFF_CYC) else $error("low gap after high too short");
    a_pins_need_supply: assert property (!at_low |-> pin_drive.supply_on)
        else $error("pulse level without supply");
    a_settle_first: assert property ($fell(pin_drive.supply_on)
        && last_ff == fuse_trim_pkg::LVL_BLOW |-> run_ff >= SETTLE_CYC)
        else $error("supply removed before settle delay");
    a_one_blow: assert property (blow_start |-> hi_ff < 3'h3)
        else $error("second blow without supply cycle");
    a_single_bit: assert property (blow_start ##0 hi_ff == 3'h2 |-> $onehot(mid_ff))
        else $error("blow on a multi-bit code");
    a_key_count: assert property (blow_start ##0 hi_ff == 3'h1
        |-> mid_ff inside {7'h1, 7'h2, 7'h3}) else $error("key count out of range");
endmodule // fuse_trim_checker

bind fuse_trim_programmer fuse_trim_checker #(
    .SETTLE_US(SETTLE_US),
    .PWR_OFF_US(PWR_OFF_US),
    .PWR_UP_US(PWR_UP_US)
) fuse_trim_checker_inst (.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .pin_drive(pin_drive));

// ### trim_device_model.sv
`timescale 1ns/1ns
module trim_device_model (
    input wire logic sys_clk,
    input wire fuse_trim_pkg::pin_drive_t pin_drive,
    output logic [1:0] key_ff,
    output logic [5:0] code_ff,
    output logic [16:0] fuse_ff
);
    fuse_trim_pkg::level_t prev_ff;
    logic [1:0] st_ff;
    logic hi_end;
    logic mid_end;
    logic [5:0] top_code;
    logic [16:0] blow_vec;
    initial
    begin
        prev_ff = fuse_trim_pkg::LVL_LOW;
        st_ff = 2'h0;
        key_ff = 2'h0;
        code_ff = 6'h0;
        fuse_ff = 17'h0; // Fresh part, every fuse intact
    end
    // Pulse events from the classified pin level
    assign hi_end = prev_ff == fuse_trim_pkg::LVL_BLOW && pin_drive.level != prev_ff;
    assign mid_end = prev_ff == fuse_trim_pkg::LVL_STEP && pin_drive.level != prev_ff;
    assign top_code = key_ff == 2'h3 ? 6'h1f : 6'h3f;
    assign blow_vec = key_ff == 2'h1 ? {11'h0, code_ff} : key_ff == 2'h2 ?
        {5'h0, code_ff, 6'h0} : {code_ff[4:0], 12'h0};
    always @(posedge sys_clk)
    begin
        prev_ff <= pin_drive.level;
        if (!pin_drive.supply_on)
        begin
            st_ff <= 2'h0;
            key_ff <= 2'h0;
            code_ff <= 6'h0;
        end
        else if (hi_end && !fuse_ff[16])
        begin
            if (st_ff == 2'h0)
                st_ff <= 2'h1; // Mid pulses before this are ignored
            else if (st_ff == 2'h1 && key_ff != 2'h0)
                st_ff <= 2'h2;
            else if (st_ff == 2'h2 && $onehot(code_ff))
            begin // Bits are only ever set, never cleared
                fuse_ff <= fuse_ff | blow_vec;
                st_ff <= 2'h3;
            end
        end
        else if (mid_end && st_ff == 2'h1 && key_ff != 2'h3)
            key_ff <= key_ff + 2'h1;
        else if (mid_end && st_ff == 2'h2 && code_ff != top_code)
            code_ff <= code_ff + 6'h1; // Held as trial DAC input
    end
endmodule // trim_device_model

// ### tb_fuse_trim_programmer.sv
`timescale 1ns/1ns
module tb_fuse_trim_programmer;
    typedef struct packed {
        logic [1:0] key;
        logic [5:0] code;
        logic [5:0] exp_code;
    } row_t;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [31:0] rdata;
    fuse_trim_pkg::pin_drive_t pin_drive;
    fuse_trim_pkg::status_word_t st;
    logic [1:0] dev_key;
    logic [5:0] dev_code;
    logic [16:0] dev_fuse;
    logic [31:0] d;
    int num_errors = 0;
    int total_checks = 0;
    // Second key 2 row is lower than the first: needs a fresh supply cycle
    row_t rows [5] = '{'{2'h1, 6'h03, 6'h03}, '{2'h2, 6'h05, 6'h05},
        '{2'h2, 6'h02, 6'h02}, '{2'h3, 6'h08, 6'h08}, '{2'h1, 6'h3f, 6'h3f}};
    // Command words: try code 0, key 0, code above 31, multi-bit blow, unknown op
    logic [13:0] bad [5] = '{14'h0011, 14'h0101, 14'h2031, 14'h0312, 14'h0117};
    fuse_trim_programmer #(.SETTLE_US(1), .PWR_OFF_US(2), .PWR_UP_US(1))
        fuse_trim_programmer_inst (.sys_clk(sys_clk), .rstn(rstn), .ce(1'b1), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .pin_drive(pin_drive));
    trim_device_model trim_device_model_inst (.sys_clk(sys_clk), .pin_drive(pin_drive),
        .key_ff(dev_key), .code_ff(dev_code), .fuse_ff(dev_fuse));
    always #50 sys_clk = ~sys_clk;
    task automatic stop_test();
        $display("Checks %0d, errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        addr <= a;
        wdata <= v;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        @(negedge sys_clk);
        v = rdata;
    endtask
    // Issues one command and polls status until the sequence is over
    task automatic run(input logic [2:0] op, input logic [1:0] k, input logic [5:0] c);
        fuse_trim_pkg::cmd_word_t w;
        int n;
        w = '0;
        w.op = fuse_trim_pkg::op_t'(op);
        w.key = k;
        w.code = c;
        wr(fuse_trim_pkg::CMD_OFS, w);
        n = 0;
        st = '1;
        while (st.busy !== 1'b0 && n < 20000)
        begin
            rd(fuse_trim_pkg::STATUS_OFS, d);
            st = d;
            n++;
        end
        if (n == 20000)
            chk("busy timeout", 32'h1, 32'h0);
    endtask
    initial
    begin
        repeat (60000) @(posedge sys_clk);
        num_errors++;
        stop_test();
    end
    initial
    begin
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(fuse_trim_pkg::STATUS_OFS, d);
        chk("status", d, 32'h0);
        chk("pin", {29'h0, pin_drive}, {29'h0, fuse_trim_pkg::PIN_DRIVE_RST});
        chk("dev code", {dev_key, dev_code}, 32'h0);
        foreach (rows[i])
        begin
            run(fuse_trim_pkg::OP_TRY, rows[i].key, rows[i].code);
            repeat (100) @(posedge sys_clk);
            chk("trial code", dev_code, rows[i].exp_code);
            chk("trial key", {dev_key, pin_drive.supply_on}, {rows[i].key, 1'b1});
            chk("status", {st.err, st.key, st.code}, {1'b0, rows[i].key, rows[i].code});
        end
        run(fuse_trim_pkg::OP_POWER_CYCLE, 2'h0, 6'h00);
        chk("power cycle", {st.err, dev_key, dev_code, pin_drive.supply_on}, 32'h1);
        foreach (bad[i])
        begin
            run(bad[i][2:0], bad[i][5:4], bad[i][13:8]);
            chk("refused", {st.busy, st.err}, 32'h1);
            wr(fuse_trim_pkg::STATUS_OFS, 32'h2);
        end
        run(fuse_trim_pkg::OP_PROGRAM, 2'h1, 6'h05);
        rd(fuse_trim_pkg::BLOWN_OFS, d);
        chk("blown", d, 32'h5);
        chk("dev fuses", dev_fuse, 32'h5);
        chk("code after cycle", dev_code, 32'h0);
        run(fuse_trim_pkg::OP_BLOW_BIT, 2'h1, 6'h02);
        chk("dev fuses", dev_fuse, 32'h7);
        run(fuse_trim_pkg::OP_BLOW_BIT, 2'h3, 6'h08);
        chk("order warn", {st.order_warn, st.err}, 32'h2);
        wr(fuse_trim_pkg::STATUS_OFS, 32'h8);
        run(fuse_trim_pkg::OP_BLOW_BIT, 2'h3, 6'h10);
        rd(fuse_trim_pkg::BLOWN_OFS, d);
        chk("blown", d, 32'h18007);
        chk("locked", {st.locked, st.err, st.order_warn}, 32'h4);
        run(fuse_trim_pkg::OP_TRY, 2'h2, 6'h01);
        chk("after lock", {st.busy, st.err, dev_fuse}, {2'h1, 17'h18007});
        rd(8'h0c, d);
        chk("unmapped", d, 32'h0);
        rd(fuse_trim_pkg::CMD_OFS, d);
        chk("cmd read", d, 32'h0);
        stop_test();
    end
endmodule // tb_fuse_trim_programmer
